// ===== tb/dmia_sfr_model.sv
`timescale 1ns/100ps
module dmia_sfr_model (
    // clock and resolved address
    input  wire logic       core_clk,
    input  wire logic [7:0] eff_addr,
    input  wire logic       eff_bank1,
    // sfr write side
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    // sfr answer
    output logic [7:0]      sfr_rdata,
    output logic            sfr_present,
    output logic            sfr_readonly
);
    logic [7:0] scratch_r = 8'h00;
    logic [7:0] noise_r   = 8'h3C;
    // one writable sfr at 06, one read-only at 0A, noise elsewhere
    always @(posedge core_clk) begin
        noise_r <= ~noise_r;
        if (sfr_wr && sfr_addr == 8'h06) begin
            scratch_r <= sfr_wdata;
        end
    end
    always_comb begin
        sfr_present  = !eff_bank1 && (eff_addr == 8'h06 || eff_addr == 8'h0A);
        sfr_readonly = !eff_bank1 && eff_addr == 8'h0A;
        sfr_rdata    = noise_r;
        if (sfr_present) begin
            sfr_rdata = (eff_addr == 8'h06) ? scratch_r : 8'h5A;
        end
    end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic       core_clk, nrst, wdt_idle_rst, mem_rd, mem_wr, alu_wr, pulse;
    logic       sfr_present, sfr_readonly, sfr_wr, bank_sel, sh_b, eff_bank1;
    logic [7:0] mem_addr, mem_wdata, alu_result, mem_rdata, work_out, q;
    logic [7:0] sfr_rdata, sfr_addr, sfr_wdata, eff_addr, sh_p0, sh_p1;
    int         failures, samples_checked;
    dmia_core dut_u (.core_clk(core_clk), .nrst(nrst), .wdt_idle_rst(wdt_idle_rst),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .alu_wr(alu_wr), .alu_result(alu_result),
        .work_out(work_out), .sfr_rdata(sfr_rdata), .sfr_present(sfr_present),
        .sfr_readonly(sfr_readonly), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .bank_sel(bank_sel));
    dmia_sfr_model sfr_u (.core_clk(core_clk), .eff_addr(eff_addr), .eff_bank1(eff_bank1),
        .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_present(sfr_present), .sfr_readonly(sfr_readonly));
    // resolved address seen by the sfr model
    always_comb begin
        eff_addr  = mem_addr;
        eff_bank1 = 1'b0;
        if (mem_addr == 8'h00) begin
            eff_addr = sh_p0;
        end else if (mem_addr == 8'h02) begin
            eff_addr  = sh_p1;
            eff_bank1 = sh_b;
        end
    end
    task automatic report_and_stop;
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        mem_wr = 1'b1; mem_addr = a; mem_wdata = d;
        @(posedge core_clk) #1;
        mem_wr = 1'b0; mem_wdata = ~d; pulse = sfr_wr;
        if (a == 8'h01) sh_p0 = d;
        if (a == 8'h03) sh_p1 = d;
        if (a == 8'h04) sh_b = d[0];
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk) #1;
        mem_rd = 1'b1; mem_addr = a;
        @(posedge core_clk) #1;
        mem_rd = 1'b0;
        check(mem_rdata, exp);
    endtask
    task automatic t_reset;
        rdc(8'h01, 8'h00);
        rdc(8'h04, 8'h00);
    endtask
    task automatic t_ptrs;
        wr(8'h01, 8'hA5); rdc(8'h01, 8'hA5);
        wr(8'h03, 8'hFF); rdc(8'h03, 8'hFF);
        wr(8'h04, 8'hFF); rdc(8'h04, 8'h01);
        check({7'h00, bank_sel}, 8'h01);
    endtask
    task automatic t_indirect;
        wr(8'h03, 8'h90); wr(8'h02, 8'h3C); wr(8'h04, 8'h00); wr(8'h90, 8'hC3);
        wr(8'h04, 8'h01); rdc(8'h90, 8'hC3);
        rdc(8'h02, 8'h3C);
        wr(8'h01, 8'h90); rdc(8'h00, 8'hC3);
        wr(8'h03, 8'hBF); wr(8'h02, 8'h66); rdc(8'h02, 8'h66);
        wr(8'h04, 8'h00); wr(8'h03, 8'h90); rdc(8'h02, 8'hC3);
    endtask
    task automatic t_virtual;
        wr(8'h01, 8'h00); rdc(8'h00, 8'h00);
        wr(8'h03, 8'h02); wr(8'h02, 8'h77); rdc(8'h02, 8'h00);
        wr(8'h01, 8'h03); rdc(8'h00, 8'h02);
        rdc(8'h61, 8'h00);
    endtask
    task automatic t_sfr;
        wr(8'h06, 8'h4B); check({7'h00, pulse}, 8'h01);
        check(sfr_addr, 8'h06);
        rdc(8'h06, 8'h4B);
        wr(8'h0A, 8'h11); check({7'h00, pulse}, 8'h00);
        rdc(8'h0A, 8'h5A);
    endtask
    task automatic t_alu;
        @(posedge core_clk) #1;
        alu_wr = 1'b1; alu_result = 8'hE7; mem_wr = 1'b1; mem_addr = 8'h05; mem_wdata = 8'h18;
        @(posedge core_clk) #1;
        alu_wr = 1'b0; mem_wr = 1'b0; alu_result = 8'h18;
        check(work_out, 8'hE7);
        rdc(8'h05, 8'hE7);
        wr(8'h05, 8'h18); check(work_out, 8'h18);
    endtask
    task automatic t_wdt;
        wr(8'h04, 8'h01);
        @(posedge core_clk) #1; nrst = 1'b0; wdt_idle_rst = 1'b1;
        @(posedge core_clk) #1; nrst = 1'b1; wdt_idle_rst = 1'b0;
        check({7'h00, bank_sel}, 8'h01);
        @(posedge core_clk) #1; nrst = 1'b0;
        @(posedge core_clk) #1; nrst = 1'b1; sh_b = 1'b0;
        check({7'h00, bank_sel}, 8'h00);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        report_and_stop;
    end
    initial begin
        failures = 0; samples_checked = 0; nrst = 1'b0; wdt_idle_rst = 1'b0;
        mem_rd = 1'b0; mem_wr = 1'b0; alu_wr = 1'b0; mem_addr = 8'h00;
        mem_wdata = 8'h00; alu_result = 8'h00; pulse = 1'b0;
        sh_p0 = 8'h00; sh_p1 = 8'h00; sh_b = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 nrst = 1'b1;
        t_reset; t_ptrs; t_indirect; t_virtual; t_sfr; t_alu; t_wdt;
        report_and_stop;
    end
endmodule

// ===== verilog/dmia_core.sv
`timescale 1ns/100ps
`include "dmia_map.svh"
// Summary of operation
// - reading an unassigned special location returns zero.
// - read-only special locations ignore writes while the rest accept writes.
// - access to an indirect port is redirected to the address in its paired pointer.
// - the first indirect port always reaches bank zero.
// - the second indirect port reaches the bank from the bank pointer with its pointer.
// - an access resolving to an indirect port in bank zero reads zero and writes nothing.
// - direct addressing always selects bank zero.
// - both pointers are real storage readable and writable like any register.
// - the working register receives every ALU result.
// - there is no register to register move; data passes the working register.
// - bank pointer bit zero selects bank zero or one, other bits read zero.
// - reset returns the bank to zero except a watchdog reset in idle or sleep.
// - special registers sit at 00H to 7FH, RAM at 80H-FFH bank 0, 80H-BFH bank 1.
module dmia_core #(
    parameter int RAM_WORDS = 192
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               wdt_idle_rst,
    // cpu data memory port
    input  wire logic               mem_rd,
    input  wire logic               mem_wr,
    input  wire logic [7:0]         mem_addr,
    input  wire dmia_pkg::dmia_byte_t mem_wdata,
    output logic [7:0]              mem_rdata,
    // alu result port
    input  wire logic               alu_wr,
    input  wire dmia_pkg::dmia_byte_t alu_result,
    output logic [7:0]              work_out,
    // external special function registers
    input  wire logic [7:0]         sfr_rdata,
    input  wire logic               sfr_present,
    input  wire logic               sfr_readonly,
    output logic                    sfr_wr,
    output logic [7:0]              sfr_addr,
    output logic [7:0]              sfr_wdata,
    output logic                    bank_sel
);
    import dmia_pkg::*;

    logic [7:0] ram [0:RAM_WORDS-1];
    logic [7:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt, work_r, work_nxt;
    logic       bank_r, bank_nxt;
    logic [7:0] rdata_r, rdata_nxt, sfr_addr_r, sfr_addr_nxt, sfr_wdata_r, sfr_wdata_nxt;
    logic       sfr_wr_r, sfr_wr_nxt;
    logic [7:0] eff_addr;
    logic       eff_bank;
    logic       ram_we;
    logic [7:0] ram_idx;
    dmia_tgt_e  tgt;

    // map address and bank to a ram row, or none
    function automatic logic [8:0] ram_row(input logic bnk, input logic [7:0] a);
        logic [8:0] r;
        r = 9'h100;
        if (a >= `DMIA_GPR_FIRST) begin
            if (!bnk)
                r = {2'b00, a[6:0]};
            else if (a <= `DMIA_GPR_B1_LAST)
                r = {3'b010, a[5:0]};
        end
        return r;
    endfunction

    // true for either indirect port address
    function automatic logic is_ind_port(input logic [7:0] a);
        return (a == `DMIA_OFS_IND0) || (a == `DMIA_OFS_IND1);
    endfunction

    always_comb begin
        logic [8:0] row;
        row = 9'h100;
        eff_addr = mem_addr;
        eff_bank = 1'b0;
        if (mem_addr == `DMIA_OFS_IND0) begin
            eff_addr = ptr0_r;
            eff_bank = 1'b0;
        end else if (mem_addr == `DMIA_OFS_IND1) begin
            eff_addr = ptr1_r;
            eff_bank = bank_r;
        end
        row = ram_row(eff_bank, eff_addr);
        ram_idx = row[7:0];
        tgt = DMIA_T_NONE;
        if (!row[8])
            tgt = DMIA_T_GPR;
        else if (eff_addr <= `DMIA_SFR_LAST && !eff_bank) begin
            if (is_ind_port(eff_addr))
                tgt = DMIA_T_NONE;
            else if (eff_addr >= `DMIA_OFS_PTR0 && eff_addr <= `DMIA_OFS_WORK)
                tgt = DMIA_T_REG;
            else if (sfr_present)
                tgt = DMIA_T_SFR;
        end else if (eff_addr <= `DMIA_SFR_LAST && sfr_present)
            tgt = DMIA_T_SFR;
    end

    always_comb begin
        ptr0_nxt = ptr0_r;
        ptr1_nxt = ptr1_r;
        bank_nxt = bank_r;
        work_nxt = work_r;
        sfr_wr_nxt = 1'b0;
        sfr_addr_nxt = sfr_addr_r;
        sfr_wdata_nxt = sfr_wdata_r;
        ram_we = 1'b0;
        rdata_nxt = `DMIA_READ_ZERO;
        if (mem_rd) begin
            case (tgt)
                DMIA_T_GPR: rdata_nxt = ram[ram_idx];
                DMIA_T_SFR: rdata_nxt = sfr_rdata;
                DMIA_T_REG: begin
                    case (eff_addr)
                        `DMIA_OFS_PTR0: rdata_nxt = ptr0_r;
                        `DMIA_OFS_PTR1: rdata_nxt = ptr1_r;
                        `DMIA_OFS_BANK: rdata_nxt = {7'h00, bank_r};
                        `DMIA_OFS_WORK: rdata_nxt = work_r;
                        default:        rdata_nxt = `DMIA_READ_ZERO;
                    endcase
                end
                default: rdata_nxt = `DMIA_READ_ZERO;
            endcase
        end
        // memory writes only carry working register or alu data
        if (mem_wr) begin
            case (tgt)
                DMIA_T_GPR: ram_we = 1'b1;
                DMIA_T_SFR: begin
                    sfr_wr_nxt = !sfr_readonly;
                    sfr_addr_nxt = eff_addr;
                    sfr_wdata_nxt = mem_wdata;
                end
                DMIA_T_REG: begin
                    case (eff_addr)
                        `DMIA_OFS_PTR0: ptr0_nxt = mem_wdata;
                        `DMIA_OFS_PTR1: ptr1_nxt = mem_wdata;
                        `DMIA_OFS_BANK: bank_nxt = mem_wdata[`DMIA_BANK_BIT];
                        `DMIA_OFS_WORK: work_nxt = mem_wdata;
                        default:        work_nxt = work_r;
                    endcase
                end
                default: ram_we = 1'b0;
            endcase
        end
        if (alu_wr)
            work_nxt = alu_result;
    end

    always_ff @(posedge core_clk) begin
        if (ram_we)
            ram[ram_idx] <= mem_wdata;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ptr0_r      <= `DMIA_RST_PTR;
            ptr1_r      <= `DMIA_RST_PTR;
            work_r      <= `DMIA_RST_WORK;
            rdata_r     <= `DMIA_READ_ZERO;
            sfr_wr_r    <= 1'b0;
            sfr_addr_r  <= 8'h00;
            sfr_wdata_r <= 8'h00;
            // bank kept on idle watchdog reset
            if (!wdt_idle_rst)
                bank_r <= `DMIA_RST_BANK;
        end else begin
            ptr0_r      <= ptr0_nxt;
            ptr1_r      <= ptr1_nxt;
            work_r      <= work_nxt;
            bank_r      <= bank_nxt;
            rdata_r     <= rdata_nxt;
            sfr_wr_r    <= sfr_wr_nxt;
            sfr_addr_r  <= sfr_addr_nxt;
            sfr_wdata_r <= sfr_wdata_nxt;
        end
    end

    assign mem_rdata = rdata_r;
    assign work_out  = work_r;
    assign sfr_wr    = sfr_wr_r;
    assign sfr_addr  = sfr_addr_r;
    assign sfr_wdata = sfr_wdata_r;
    assign bank_sel  = bank_r;

    a_ind_self_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_rd && mem_addr == `DMIA_OFS_IND0 && ptr0_r == `DMIA_OFS_IND0
        |=> mem_rdata == 8'h00) else $error("indirect self read not zero");
    a_alu_work_load: assert property (@(posedge core_clk) disable iff (!nrst)
        alu_wr |=> work_out == $past(alu_result))
        else $error("working register missed alu result");
    a_bank_read_form: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_rd && mem_addr == `DMIA_OFS_BANK |=> mem_rdata[7:1] == 7'h00)
        else $error("bank pointer upper bits not zero");
    a_ptr_write_back: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && mem_addr == `DMIA_OFS_PTR1 |=> ptr1_r == $past(mem_wdata))
        else $error("pointer one not written");
    a_sfr_ro_block: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && tgt == DMIA_T_SFR && sfr_readonly |=> !sfr_wr)
        else $error("write reached read-only location");
    a_port0_bank: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_addr == `DMIA_OFS_IND0 |-> !eff_bank && eff_addr == ptr0_r)
        else $error("port zero left bank zero");
    a_port1_bank: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_addr == `DMIA_OFS_IND1 |-> eff_bank == bank_r && eff_addr == ptr1_r)
        else $error("port one bank wrong");
    a_direct_bank: assert property (@(posedge core_clk) disable iff (!nrst)
        !is_ind_port(mem_addr) |-> !eff_bank)
        else $error("direct access left bank zero");
    a_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_rd && tgt == DMIA_T_NONE |=> mem_rdata == 8'h00)
        else $error("unused location read nonzero");
    a_bank1_hole: assert property (@(posedge core_clk) disable iff (!nrst)
        eff_bank && eff_addr > `DMIA_GPR_B1_LAST |-> tgt == DMIA_T_NONE)
        else $error("bank one hole mapped");
    a_bank_reset_zero: assert property (@(posedge core_clk)
        !nrst && !wdt_idle_rst |=> !bank_sel)
        else $error("bank not cleared by reset");
    a_bank_wdt_keep: assert property (@(posedge core_clk)
        !nrst && wdt_idle_rst |=> bank_sel == $past(bank_sel))
        else $error("bank changed by idle watchdog reset");
    a_ptr0_write: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && mem_addr == `DMIA_OFS_PTR0 |=> ptr0_r == $past(mem_wdata))
        else $error("pointer zero not written");
    a_ptr0_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !mem_wr |=> ptr0_r == $past(ptr0_r))
        else $error("pointer zero changed without write");
    a_ptr1_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !mem_wr |=> ptr1_r == $past(ptr1_r))
        else $error("pointer one changed without write");
    a_bank_write: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && mem_addr == `DMIA_OFS_BANK |=> bank_sel == $past(mem_wdata[`DMIA_BANK_BIT]))
        else $error("bank bit not written");
    a_bank_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !mem_wr |=> bank_sel == $past(bank_sel))
        else $error("bank changed without write");
    a_work_write: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && mem_addr == `DMIA_OFS_WORK && !alu_wr |=> work_out == $past(mem_wdata))
        else $error("working register not written");
    a_ind_write_none: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && tgt == DMIA_T_NONE |=> ptr0_r == $past(ptr0_r)
        && ptr1_r == $past(ptr1_r) && bank_sel == $past(bank_sel) && !sfr_wr)
        else $error("write to unassigned location took effect");
    a_ram_no_write: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && tgt != DMIA_T_GPR |-> !ram_we)
        else $error("ram written outside ram window");
    a_redirect_reg: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_rd && mem_addr == `DMIA_OFS_IND0 && ptr0_r == `DMIA_OFS_PTR1
        |=> mem_rdata == $past(ptr1_r))
        else $error("indirect read not redirected");
    a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        !mem_rd |=> mem_rdata == 8'h00)
        else $error("read data nonzero without read");
    a_sfr_pass: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_wr && tgt == DMIA_T_SFR && !sfr_readonly
        |=> sfr_wr && sfr_addr == $past(eff_addr) && sfr_wdata == $past(mem_wdata))
        else $error("sfr write not passed on");
    a_rd_sfr_pass: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_rd && tgt == DMIA_T_SFR |=> mem_rdata == $past(sfr_rdata))
        else $error("sfr read data lost");
    a_sfr_no_spurious: assert property (@(posedge core_clk) disable iff (!nrst)
        !mem_wr |=> !sfr_wr)
        else $error("sfr write pulse without write");
    a_ram_row_range: assert property (@(posedge core_clk) disable iff (!nrst)
        tgt == DMIA_T_GPR |-> ram_idx < RAM_WORDS)
        else $error("ram row out of range");
    a_bank1_row: assert property (@(posedge core_clk) disable iff (!nrst)
        tgt == DMIA_T_GPR && eff_bank |-> ram_idx >= 8'h80)
        else $error("bank one row overlaps bank zero");
endmodule

// ===== verilog/dmia_map.svh
`ifndef DMIA_MAP_SVH
`define DMIA_MAP_SVH
`define DMIA_OFS_IND0      8'h00
`define DMIA_OFS_PTR0      8'h01
`define DMIA_OFS_IND1      8'h02
`define DMIA_OFS_PTR1      8'h03
`define DMIA_OFS_BANK      8'h04
`define DMIA_OFS_WORK      8'h05
`define DMIA_SFR_LAST      8'h7F
`define DMIA_GPR_FIRST     8'h80
`define DMIA_GPR_B1_LAST   8'hBF
`define DMIA_BANK_BIT      0
`define DMIA_RST_PTR       8'h00
`define DMIA_RST_WORK      8'h00
`define DMIA_RST_BANK      1'b0
`define DMIA_READ_ZERO     8'h00
`endif

// ===== verilog/dmia_pkg.sv
package dmia_pkg;
    typedef logic [7:0] dmia_byte_t;
    typedef enum logic [1:0] {
        DMIA_T_NONE = 2'b00,
        DMIA_T_REG  = 2'b01,
        DMIA_T_GPR  = 2'b10,
        DMIA_T_SFR  = 2'b11
    } dmia_tgt_e;
endpackage
